// ---- verilog/mcd_pkg.sv ----
// constants shared by the controller end and the mirror clear driver end
package mcd_pkg;
  // link timing: serial port clock period and the system clock period
  localparam int SYS_PERIOD_NS = 100;
  localparam int SCP_PERIOD_NS = 800;
  localparam int SCP_HALF_CYC = SCP_PERIOD_NS / (2 * SYS_PERIOD_NS);
  // latch strobe shaping on the controller end, in system cycles
  localparam int STB_SETUP_CYC = 2;
  localparam int STB_HIGH_CYC = 4;
  // serial frame: one command byte (read flag, 7-bit address), one data byte
  localparam int SCP_FRAME_BITS = 16;
  localparam int SCP_CMD_BITS = 8;
  localparam int SCP_RD_BIT = 7;
  // serial register offsets
  localparam logic [6:0] REG_REGUL = 7'h00;
  localparam logic [6:0] REG_IRQ = 7'h01;
  localparam logic [6:0] REG_LATCH = 7'h02;
  localparam logic [6:0] REG_STAT = 7'h03;
  // field positions
  localparam int REGUL_BIAS_BIT = 0;
  localparam int REGUL_OFFS_BIT = 1;
  localparam int REGUL_NEG_BIT = 2;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int STAT_DRV_BIT = 0;
  localparam int STAT_OFFS_BIT = 1;
  // reset values, and the value read back from unmapped offsets
  localparam logic [2:0] REGUL_RST = 3'h0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage : mcd_pkg

// ---- verilog/mcd_link_if.sv ----
// pins between the display controller end and the mirror clear driver end
`timescale 1ns/1ns
interface mcd_link_if;
  // values the controller puts out, and whether it drives each group
  logic h_strobe;
  logic [3:0] h_addr;
  logic [1:0] h_mode;
  logic [1:0] h_level;
  logic h_out_en_n;
  logic h_init_n;
  logic h_clock;
  logic h_din;
  logic h_enable_n;
  logic ctl_oe;
  logic scp_oe;
  // pin levels as the device sees them, with the internal pulls applied
  logic clear_ctrl_latch_strobe;
  logic [3:0] drv_addr_sel;
  logic [1:0] drv_mode_sel;
  logic [1:0] drv_level_sel;
  logic clear_driver_out_en_n;
  logic clear_circuit_init_n;
  logic serial_port_clock;
  logic serial_port_din;
  logic serial_port_enable_n;
  // device outputs
  logic serial_port_dout;
  logic bias_regulator_enable;
  logic offset_regulator_enable;
  logic neg_level_regulator_enable;
  logic clear_driver_irq_n;
  // undriven inputs fall to their pull level
  assign clear_ctrl_latch_strobe = ctl_oe ? h_strobe : 1'b0;
  assign drv_addr_sel = ctl_oe ? h_addr : 4'h0;
  assign drv_mode_sel = ctl_oe ? h_mode : 2'h0;
  assign drv_level_sel = ctl_oe ? h_level : 2'h0;
  assign clear_driver_out_en_n = ctl_oe ? h_out_en_n : 1'b1;
  assign clear_circuit_init_n = ctl_oe ? h_init_n : 1'b0;
  assign serial_port_clock = scp_oe ? h_clock : 1'b0;
  assign serial_port_din = scp_oe ? h_din : 1'b0;
  assign serial_port_enable_n = scp_oe ? h_enable_n : 1'b0;
  modport ctrl (
    output h_strobe, h_addr, h_mode, h_level, h_out_en_n, h_init_n,
    output h_clock, h_din, h_enable_n, ctl_oe, scp_oe,
    input serial_port_dout, bias_regulator_enable, offset_regulator_enable,
    input neg_level_regulator_enable, clear_driver_irq_n
  );
  modport dev (
    input clear_ctrl_latch_strobe, drv_addr_sel, drv_mode_sel, drv_level_sel,
    input clear_driver_out_en_n, clear_circuit_init_n,
    input serial_port_clock, serial_port_din, serial_port_enable_n,
    output serial_port_dout, bias_regulator_enable, offset_regulator_enable,
    output neg_level_regulator_enable, clear_driver_irq_n
  );
endinterface : mcd_link_if

// ---- verilog/mcd_device.sv ----
// mirror clear driver control end: latch, driver gating, serial port, regulator enables
//
// Overview of operation
// (RULE1) strobe rising edge captures address, mode, level
// (RULE2) four-bit address select, undriven bits read zero
// (RULE3) two-bit mode select, pulled down to zero
// (RULE4) two-bit level select, pulled down to zero
// (RULE5) clear drivers enabled only while enable low
// (RULE6) init low forces clear circuitry to offset
// (RULE7) serial clock ignored while port enable high
// (RULE8) serial input sampled on rising clock edges
// (RULE9) controller frames each transaction with enable low
// (RULE10) read data returned on serial output pin
// (RULE11) bias regulator enable high on, low off
// (RULE12) offset regulator enable high on, low off
// (RULE13) negative-level regulator enable high on, low off
// (RULE14) interrupt shown by driving irq pin low
// (RULE15) bit counter cleared whenever port enable high
// (RULE16) serial output changes on falling clock edge
`timescale 1ns/1ns
module mcd_device
  import mcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  mcd_link_if.dev link,
  output logic [3:0] latched_addr,
  output logic [1:0] latched_mode,
  output logic [1:0] latched_level,
  output logic drivers_enabled,
  output logic held_at_offset
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    // pin synchronisers; the third stage of a chain is edge history only
    logic [2:0] stb_s;
    logic [2:0] clk_s;
    logic [1:0] en_s;
    logic [1:0] din_s;
    logic [1:0] oen_s;
    logic [1:0] init_s;
    logic [7:0] ctl_s1;
    logic [7:0] ctl_s2;
    // control latch contents
    logic [3:0] addr_l;
    logic [1:0] mode_l;
    logic [1:0] level_l;
    // serial shifters and frame position
    logic [4:0] bit_cnt;
    logic [7:0] cmd;
    logic [7:0] wsh;
    logic [7:0] rsh;
    logic dout;
    // serial registers and status
    logic [2:0] regul;
    logic irq_en;
    logic irq_flag;
    logic irq_n;
    logic drv_en;
    logic at_offset;
  } mcd_dev_st_type;

  mcd_dev_st_type r;
  mcd_dev_st_type n;

  // edge finders on the synchronised stage and its history
  // the first sync flop never reaches these; only stages two and three are compared
  function automatic logic mcd_rise(input logic [2:0] s);
    mcd_rise = s[1] & ~s[2];
  endfunction : mcd_rise

  function automatic logic mcd_fall(input logic [2:0] s);
    mcd_fall = ~s[1] & s[2];
  endfunction : mcd_fall

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic en_lo;
    logic [7:0] in_byte;
    logic [7:0] rd_val;
    en_lo = 1'b0;
    in_byte = 8'h00;
    rd_val = UNMAPPED_RD;
    n = r;
    // everything holds by default; each section below overrides its own fields
    // two sync flops on every pin, the first only feeding the second; strobe and clock keep a third for history
    n.stb_s = {r.stb_s[1:0], link.clear_ctrl_latch_strobe};
    n.clk_s = {r.clk_s[1:0], link.serial_port_clock};
    n.en_s = {r.en_s[0], link.serial_port_enable_n};
    n.din_s = {r.din_s[0], link.serial_port_din};
    n.oen_s = {r.oen_s[0], link.clear_driver_out_en_n};
    n.init_s = {r.init_s[0], link.clear_circuit_init_n};
    // fields ride the same sync depth as the strobe so they stay aligned
    n.ctl_s1 = {link.drv_level_sel, link.drv_mode_sel, link.drv_addr_sel}; // RULE2 RULE3 RULE4
    n.ctl_s2 = r.ctl_s1;

    // control latch; init low clears it rather than capturing
    // the edge is found two flops late, so the fields come from the matching sync stage
    if (!r.init_s[1]) begin
      n.addr_l = 4'h0; // RULE6
      n.mode_l = 2'h0;
      n.level_l = 2'h0;
    end else if (mcd_rise(r.stb_s)) begin
      n.addr_l = r.ctl_s2[3:0]; // RULE1
      n.mode_l = r.ctl_s2[5:4];
      n.level_l = r.ctl_s2[7:6];
    end
    n.at_offset = ~r.init_s[1]; // RULE6
    // init low overrides the output enable so drivers stay parked
    n.drv_en = ~r.oen_s[1] & r.init_s[1]; // RULE5

    // register readback for the serial port
    // the address is taken one bit early, from the shifter plus the bit now arriving
    case (in_byte[6:0])
      default: rd_val = UNMAPPED_RD;
    endcase
    in_byte = {r.wsh[6:0], r.din_s[1]};
    case (in_byte[6:0])
      REG_REGUL: rd_val = {5'h00, r.regul};
      REG_IRQ: rd_val = {6'h00, r.irq_en, r.irq_flag};
      REG_LATCH: rd_val = {r.level_l, r.mode_l, r.addr_l};
      REG_STAT: rd_val = {6'h00, r.at_offset, r.drv_en};
      default: rd_val = UNMAPPED_RD;
    endcase

    // serial port; edges only count inside an enabled frame
    // a frame cut short leaves nothing behind: writes only land on the sixteenth edge
    en_lo = ~r.en_s[1];
    if (!en_lo) begin
      n.bit_cnt = 5'h00; // RULE15 RULE7
      n.dout = 1'b0;
    end else begin
      if (mcd_rise(r.clk_s) && r.bit_cnt < 5'(SCP_FRAME_BITS)) begin
        n.wsh = in_byte; // RULE8
        n.bit_cnt = r.bit_cnt + 5'h01;
        if (r.bit_cnt == 5'(SCP_CMD_BITS - 1)) begin
          n.cmd = in_byte;
          n.rsh = rd_val;
        end
        // write lands on the last rising edge of a write frame
        // unmapped or read-only offsets drop the write
        if (r.bit_cnt == 5'(SCP_FRAME_BITS - 1) && !r.cmd[SCP_RD_BIT]) begin
          case (r.cmd[6:0])
            REG_REGUL: n.regul = in_byte[2:0];
            REG_IRQ: begin
              n.irq_en = in_byte[IRQ_EN_BIT];
              if (in_byte[IRQ_FLAG_BIT]) begin
                n.irq_flag = 1'b0;
              end
            end
            default: n.regul = r.regul;
          endcase
        end
      end
      // shift read data out after the controller's sample point late in the high phase
      // sync flops at both ends eat five cycles, so the half period must stay at three or more
      if (mcd_fall(r.clk_s) && r.cmd[SCP_RD_BIT] && r.bit_cnt >= 5'(SCP_CMD_BITS)
          && r.bit_cnt < 5'(SCP_FRAME_BITS)) begin
        n.dout = r.rsh[7]; // RULE16 RULE10
        n.rsh = {r.rsh[6:0], 1'b0};
      end
    end

    // each accepted latch is an event; set beats a same-cycle clear
    // the flag stays set until written off, so a strobe event cannot slip by unseen
    if (r.init_s[1] && mcd_rise(r.stb_s)) begin
      n.irq_flag = 1'b1;
    end
    n.irq_n = ~(n.irq_flag & n.irq_en); // RULE14
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  // sync reset; enables come up inactive so no false frame or driver enable follows release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
      r.oen_s <= 2'h3;
      r.en_s <= 2'h3;
      r.regul <= REGUL_RST;
      r.irq_en <= IRQ_EN_RST;
      r.irq_n <= 1'b1;
      r.at_offset <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops
  // link pins towards the controller
  assign link.serial_port_dout = r.dout;
  assign link.bias_regulator_enable = r.regul[REGUL_BIAS_BIT]; // RULE11
  assign link.offset_regulator_enable = r.regul[REGUL_OFFS_BIT]; // RULE12
  assign link.neg_level_regulator_enable = r.regul[REGUL_NEG_BIT]; // RULE13
  assign link.clear_driver_irq_n = r.irq_n;

  // local status, for the board and the bench
  assign latched_addr = r.addr_l;
  assign latched_mode = r.mode_l;
  assign latched_level = r.level_l;
  assign drivers_enabled = r.drv_en;
  assign held_at_offset = r.at_offset;

endmodule : mcd_device

// ---- verilog/mcd_ctrl.sv ----
// display controller end: drives latch strobe, control levels and serial frames
`timescale 1ns/1ns
module mcd_ctrl
  import mcd_pkg::*;
#(
  parameter int HALF_CYC = SCP_HALF_CYC
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  mcd_link_if.ctrl link,
  input wire logic [3:0] ctl_addr,
  input wire logic [1:0] ctl_mode,
  input wire logic [1:0] ctl_level,
  input wire logic latch_req,
  input wire logic drv_out_en,
  input wire logic circuit_init,
  input wire logic scp_req,
  input wire logic scp_read,
  input wire logic [6:0] scp_addr,
  input wire logic [7:0] scp_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] scp_rdata,
  output logic irq_pending,
  output logic [2:0] regul_seen
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {
    MCD_IDLE = 2'b00,
    MCD_LATCH = 2'b01,
    MCD_SERIAL = 2'b11,
    MCD_DONE = 2'b10
  } mcd_ctl_state_type;

  typedef struct packed {
    mcd_ctl_state_type st;
    logic [7:0] cnt;
    logic [4:0] bit_idx;
    logic [15:0] sh;
    logic [7:0] rdata;
    logic strobe;
    logic [7:0] ctl;
    logic out_en_n;
    logic init_n;
    logic sclk;
    logic din;
    logic enable_n;
    logic [1:0] dout_s;
    logic [1:0] irq_s;
    logic [5:0] regul_s;
    logic busy;
    logic done;
  } mcd_ctl_st_type;

  mcd_ctl_st_type r;
  mcd_ctl_st_type n;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = r;
    n.dout_s = {r.dout_s[0], link.serial_port_dout};
    n.irq_s = {r.irq_s[0], ~link.clear_driver_irq_n};
    n.regul_s = {r.regul_s[2:0], link.neg_level_regulator_enable,
                 link.offset_regulator_enable, link.bias_regulator_enable};
    n.out_en_n = ~drv_out_en;
    n.init_n = ~circuit_init;
    n.done = 1'b0;
    n.cnt = r.cnt + 8'h01;
    case (r.st)
      MCD_IDLE: begin
        n.cnt = 8'h00;
        // latch wins when both arrive together
        if (latch_req) begin
          n.st = MCD_LATCH;
          n.busy = 1'b1;
          n.ctl = {ctl_level, ctl_mode, ctl_addr}; // RULE2
        end else if (scp_req) begin
          n.st = MCD_SERIAL;
          n.busy = 1'b1;
          n.sh = {scp_read, scp_addr, scp_wdata};
          n.din = scp_read;
          n.enable_n = 1'b0; // RULE9
          n.bit_idx = 5'h00;
        end
      end
      MCD_LATCH: begin
        // fields settle before the edge and stay put after it
        if (r.cnt == 8'(STB_SETUP_CYC)) begin
          n.strobe = 1'b1; // RULE1
        end
        if (r.cnt == 8'(STB_SETUP_CYC + STB_HIGH_CYC)) begin
          n.strobe = 1'b0;
          n.st = MCD_DONE;
        end
      end
      MCD_SERIAL: begin
        if (r.cnt == 8'(HALF_CYC - 1)) begin
          n.cnt = 8'h00;
          n.sclk = ~r.sclk;
          // sample late in the high phase: the reply went through two flops
          if (r.sclk) begin
            if (r.bit_idx >= 5'(SCP_CMD_BITS)) begin
              n.rdata = {r.rdata[6:0], r.dout_s[1]};
            end
            n.sh = {r.sh[14:0], 1'b0};
            n.din = r.sh[14]; // RULE8
            n.bit_idx = r.bit_idx + 5'h01;
            if (r.bit_idx == 5'(SCP_FRAME_BITS - 1)) begin
              n.enable_n = 1'b1;
              n.st = MCD_DONE;
            end
          end
        end
      end
      MCD_DONE: begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.st = MCD_IDLE;
      end
      default: n.st = MCD_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= MCD_IDLE;
      r.out_en_n <= 1'b1;
      r.enable_n <= 1'b1;
      r.irq_s <= 2'h0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; the controller always drives its pins once out of reset
  assign link.h_strobe = r.strobe;
  assign link.h_addr = r.ctl[3:0];
  assign link.h_mode = r.ctl[5:4];
  assign link.h_level = r.ctl[7:6];
  assign link.h_out_en_n = r.out_en_n;
  assign link.h_init_n = r.init_n;
  assign link.h_clock = r.sclk;
  assign link.h_din = r.din;
  assign link.h_enable_n = r.enable_n;
  assign link.ctl_oe = 1'b1;
  assign link.scp_oe = 1'b1;
  assign busy = r.busy;
  assign done = r.done;
  assign scp_rdata = r.rdata;
  assign irq_pending = r.irq_s[1]; // RULE14
  assign regul_seen = r.regul_s[5:3];

endmodule : mcd_ctrl

// ---- bench/mcd_link_assertions.sv ----
// concurrent checks on the link between the controller end and the device end
`timescale 1ns/1ns
module mcd_link_assertions
  import mcd_pkg::*;
#(
  parameter int HALF_CYC = SCP_HALF_CYC
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear_ctrl_latch_strobe,
  input wire logic [3:0] drv_addr_sel,
  input wire logic [1:0] drv_mode_sel,
  input wire logic [1:0] drv_level_sel,
  input wire logic serial_port_clock,
  input wire logic serial_port_din,
  input wire logic serial_port_enable_n,
  input wire logic serial_port_dout,
  input wire logic bias_regulator_enable,
  input wire logic offset_regulator_enable,
  input wire logic neg_level_regulator_enable,
  input wire logic clear_driver_irq_n
);
  localparam int FRAME_LOW = 2 * HALF_CYC * SCP_FRAME_BITS;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  // ages since clock fall, frame end and strobe rise; low cycles of a frame
  logic [3:0] fall_cnt, idle_cnt, stb_cnt;
  logic [7:0] low_cnt;
  logic [7:0] fields;
  assign fields = {drv_level_sel, drv_mode_sel, drv_addr_sel};
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fall_cnt <= 4'hf;
      idle_cnt <= 4'hf;
      stb_cnt <= 4'hf;
      low_cnt <= 8'h00;
    end else begin
      fall_cnt <= $fell(serial_port_clock) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hf};
      idle_cnt <= !serial_port_enable_n ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'hf};
      stb_cnt <= $rose(clear_ctrl_latch_strobe) ? 4'h0 : stb_cnt + {3'h0, stb_cnt != 4'hf};
      low_cnt <= serial_port_enable_n ? 8'h00 : low_cnt + 8'h01; // saturation unneeded, frames are short
    end
  end
  ////////////////////////////////////////////////////////////////
  // strobe pulse steps and field hold around it
  sequence s_stb_high;
    clear_ctrl_latch_strobe [*4] ##1 !clear_ctrl_latch_strobe;
  endsequence
  sequence s_fields_held;
    $stable(fields) [*5];
  endsequence
  a_strobe_width: assert property ($rose(clear_ctrl_latch_strobe) |-> s_stb_high)
    else $error("latch strobe width wrong");
  a_fields_setup: assert property ($rose(clear_ctrl_latch_strobe) |-> $past(fields, 2) == fields ##0 s_fields_held)
    else $error("latch fields moved near strobe");
  a_clock_idle: assert property (serial_port_enable_n |-> !serial_port_clock)
    else $error("serial clock runs outside frame");
  a_din_on_fall: assert property ($changed(serial_port_din) |->
    $fell(serial_port_clock) || $fell(serial_port_enable_n) || serial_port_enable_n)
    else $error("serial input moved off falling edge");
  a_frame_length: assert property ($rose(serial_port_enable_n) |-> low_cnt == 8'(FRAME_LOW))
    else $error("frame length wrong");
  a_dout_on_fall: assert property (!serial_port_enable_n && $changed(serial_port_dout) |-> fall_cnt < 4'h7)
    else $error("serial output moved off falling edge");
  a_regul_by_frame: assert property ($changed({neg_level_regulator_enable, offset_regulator_enable,
    bias_regulator_enable}) |-> !serial_port_enable_n || idle_cnt < 4'h8)
    else $error("regulator enable moved without a write");
  a_irq_has_cause: assert property ($changed(clear_driver_irq_n) |->
    stb_cnt < 4'h8 || !serial_port_enable_n || idle_cnt < 4'h8)
    else $error("interrupt moved without cause");
endmodule : mcd_link_assertions

// ---- bench/mirror_clear_driver_ctrl_port_tb.sv ----
// bench joining controller end and device end, plus a device driven by hand
`timescale 1ns/1ns
module mirror_clear_driver_ctrl_port_tb;
  import mcd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] ctl_addr = 4'h0;
  logic [1:0] ctl_mode = 2'h0, ctl_level = 2'h0;
  logic latch_req = 1'b0, drv_out_en = 1'b0, circuit_init = 1'b0, scp_req = 1'b0, scp_read = 1'b0;
  logic [6:0] scp_addr = 7'h00;
  logic [7:0] scp_wdata = 8'h00, scp_rdata, rd;
  logic busy, done, irq_pending, drivers_enabled, held_at_offset, drv_b, held_b;
  logic [2:0] regul_seen;
  logic [3:0] latched_addr;
  logic [1:0] latched_mode, latched_level;
  logic [2:0] pats [5] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h0};
  int fail_count = 0, checked = 0, cycles = 0;
  mcd_link_if link();
  mcd_link_if link_b();
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////
  mcd_ctrl #(.HALF_CYC(SCP_HALF_CYC)) u_mcd_ctrl(.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .ctl_addr(ctl_addr), .ctl_mode(ctl_mode), .ctl_level(ctl_level), .latch_req(latch_req),
    .drv_out_en(drv_out_en), .circuit_init(circuit_init), .scp_req(scp_req), .scp_read(scp_read),
    .scp_addr(scp_addr), .scp_wdata(scp_wdata), .busy(busy), .done(done), .scp_rdata(scp_rdata),
    .irq_pending(irq_pending), .regul_seen(regul_seen));
  mcd_device u_mcd_device(.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .latched_addr(latched_addr),
    .latched_mode(latched_mode), .latched_level(latched_level), .drivers_enabled(drivers_enabled),
    .held_at_offset(held_at_offset));
  // second device sees the bench in the controller's place, for undriven and rogue pins
  mcd_device u_mcd_device_b(.clk_sys(clk_sys), .rst_n(rst_n), .link(link_b), .latched_addr(),
    .latched_mode(), .latched_level(), .drivers_enabled(drv_b), .held_at_offset(held_b));
  mcd_link_assertions #(.HALF_CYC(SCP_HALF_CYC)) u_mcd_link_assertions(.clk_sys(clk_sys), .rst_n(rst_n),
    .clear_ctrl_latch_strobe(link.clear_ctrl_latch_strobe), .drv_addr_sel(link.drv_addr_sel),
    .drv_mode_sel(link.drv_mode_sel), .drv_level_sel(link.drv_level_sel),
    .serial_port_clock(link.serial_port_clock), .serial_port_din(link.serial_port_din),
    .serial_port_enable_n(link.serial_port_enable_n), .serial_port_dout(link.serial_port_dout),
    .bias_regulator_enable(link.bias_regulator_enable), .offset_regulator_enable(link.offset_regulator_enable),
    .neg_level_regulator_enable(link.neg_level_regulator_enable), .clear_driver_irq_n(link.clear_driver_irq_n));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // bounded wait for the controller's completion pulse
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #10;
      n++;
    end while (done !== 1'b1 && n < 300);
    if (n >= 300) chk(8'h00, 8'h01);
  endtask : wait_done
  task automatic do_latch(input logic [3:0] a, input logic [1:0] m, input logic [1:0] l);
    ctl_addr = a;
    ctl_mode = m;
    ctl_level = l;
    latch_req = 1'b1;
    @(posedge clk_sys);
    #10;
    latch_req = 1'b0;
    chk(busy, 8'h01);
    wait_done();
    chk(busy, 8'h00);
  endtask : do_latch
  task automatic scp(input logic r, input logic [6:0] a, input logic [7:0] w);
    scp_read = r;
    scp_addr = a;
    scp_wdata = w;
    scp_req = 1'b1;
    @(posedge clk_sys);
    #10;
    scp_req = 1'b0;
    chk(busy, 8'h01);
    wait_done();
    rd = scp_rdata;
    chk(busy, 8'h00);
  endtask : scp
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #10;
  endtask : settle
  // hand-driven frame on the second device: din moves with the falling edge, nbits rising edges
  task automatic bang(input logic [15:0] w, input int nbits);
    link_b.h_enable_n = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      link_b.h_din = w[15 - k];
      repeat (4) @(posedge clk_sys);
      #10;
      link_b.h_clock = 1'b1;
      repeat (4) @(posedge clk_sys);
      #10;
      link_b.h_clock = 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    #10;
    link_b.h_enable_n = 1'b1;
    settle();
  endtask : bang
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 12000) begin
      fail_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {link_b.ctl_oe, link_b.scp_oe, link_b.h_strobe, link_b.h_addr, link_b.h_mode, link_b.h_level} = 11'h000;
    {link_b.h_out_en_n, link_b.h_init_n, link_b.h_clock, link_b.h_din, link_b.h_enable_n} = 5'h10;
    repeat (16) @(posedge clk_sys);
    #10;
    rst_n = 1'b1;
    drv_out_en = 1'b1;
    settle();
    chk(link.bias_regulator_enable | link.offset_regulator_enable | link.neg_level_regulator_enable, 8'h00);
    chk(link.clear_driver_irq_n, 8'h01);
    chk({drivers_enabled, held_at_offset}, 8'h02);
    $display("end of test: reset");
    for (int i = 0; i < 4; i++) begin
      do_latch(4'(i * 5), 2'(i), 2'(3 - i));
      chk({latched_level, latched_mode, latched_addr}, {2'(3 - i), 2'(i), 4'(i * 5)});
      scp(1'b1, REG_LATCH, 8'h00);
      chk(rd, {2'(3 - i), 2'(i), 4'(i * 5)});
    end
    $display("end of test: latch");
    foreach (pats[i]) begin
      scp(1'b0, REG_REGUL, {5'h00, pats[i]});
      settle();
      chk({link.neg_level_regulator_enable, link.offset_regulator_enable, link.bias_regulator_enable}, pats[i]);
      chk(regul_seen, pats[i]);
      scp(1'b1, REG_REGUL, 8'h00);
      chk(rd, {5'h00, pats[i]});
    end
    $display("end of test: regulators");
    scp(1'b0, REG_IRQ, 8'h02);
    settle();
    chk({link.clear_driver_irq_n, irq_pending}, 8'h01);
    scp(1'b0, REG_IRQ, 8'h03);
    settle();
    chk({link.clear_driver_irq_n, irq_pending}, 8'h02);
    do_latch(4'hf, 2'h3, 2'h3);
    settle();
    chk(link.clear_driver_irq_n, 8'h00);
    scp(1'b0, REG_IRQ, 8'h00);
    settle();
    chk(link.clear_driver_irq_n, 8'h01);
    scp(1'b1, REG_IRQ, 8'h00);
    chk(rd, 8'h01);
    $display("end of test: interrupt");
    scp(1'b0, 7'h40, 8'hff);
    scp(1'b1, 7'h7f, 8'h00);
    chk(rd, UNMAPPED_RD);
    scp(1'b1, REG_REGUL, 8'h00);
    chk(rd, 8'h00);
    scp(1'b1, REG_STAT, 8'h00);
    chk(rd, 8'h01);
    circuit_init = 1'b1;
    settle();
    chk({drivers_enabled, held_at_offset, latched_addr}, 8'h10);
    do_latch(4'h9, 2'h1, 2'h2);
    settle();
    chk({latched_level, latched_mode, latched_addr}, 8'h00);
    scp(1'b1, REG_STAT, 8'h00);
    chk(rd, 8'h02);
    $display("end of test: init");
    // undriven pins fall to their pulls; then a rogue clock while the enable is high
    chk({drv_b, held_b}, 8'h01);
    {link_b.ctl_oe, link_b.h_init_n, link_b.h_out_en_n} = 3'h6;
    settle();
    chk({drv_b, held_b}, 8'h02);
    {link_b.scp_oe, link_b.h_enable_n, link_b.h_din} = 3'h6;
    // a rogue write of all ones to the regulators, clocked while the enable is high
    for (int k = 0; k < 64; k++) begin
      repeat (4) @(posedge clk_sys);
      #10;
      link_b.h_din = (k >= 16);
      link_b.h_clock = ~link_b.h_clock;
    end
    settle();
    chk({link_b.serial_port_dout, link_b.neg_level_regulator_enable, link_b.offset_regulator_enable,
      link_b.bias_regulator_enable, link_b.clear_driver_irq_n}, 8'h01);
    // a cut frame must not shift the next one
    bang(16'hffff, 3);
    bang({1'b0, REG_REGUL, 8'h05}, 16);
    chk({link_b.neg_level_regulator_enable, link_b.offset_regulator_enable,
      link_b.bias_regulator_enable}, 8'h05);
    $display("end of test: pins");
    report_and_stop();
  end
endmodule : mirror_clear_driver_ctrl_port_tb
